// *** pmic_pkg.sv ***
// Purpose: shared constants and state types of the power state controller and serial target
// Assumes: CLK at 125 MHz
// Notes:   register indices are byte pointers sent by the serial master
package pmic_pkg;
  // clock and glitch timing
  localparam int CLK_NS     = 8;
  localparam int GLITCH_NS  = 50;
  // rejected pulse length, least time rounded up to whole cycles
  localparam int GLITCH_CYC = (GLITCH_NS + CLK_NS - 1) / CLK_NS;

  // four selectable target addresses
  localparam logic [6:0] TGT_ADDR_0 = 7'h25;
  localparam logic [6:0] TGT_ADDR_1 = 7'h27;
  localparam logic [6:0] TGT_ADDR_2 = 7'h67;
  localparam logic [6:0] TGT_ADDR_3 = 7'h6B;

  // register indices
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_MASK   = 8'h01;
  localparam logic [7:0] REG_VOUT   = 8'h02;
  localparam logic [7:0] REG_FLTCFG = 8'h03;

  // reset values
  localparam logic [7:0] MASK_RST       = 8'h00;
  localparam logic [7:0] VOUT_FACTORY   = 8'h00;
  localparam logic [7:0] FLTCFG_FACTORY = 8'h00;
  localparam logic [1:0] ADDR_SEL_RST   = 2'h0;

  // fault configuration fields
  localparam int FLT_LATCH_BIT = 0;
  localparam int FLT_THR_LSB   = 1;

  // filtered input bit positions
  localparam int FB_SCL  = 0;
  localparam int FB_SDA  = 1;
  localparam int FB_UV   = 2;
  localparam int FB_OV   = 3;
  localparam int FB_GOOD = 4;
  localparam int FB_LP   = 5;
  localparam int FB_FLT  = 6;

  typedef enum logic [2:0] {
    P_RESET  = 3'h1,
    P_SEQ    = 3'h2,
    P_ACTIVE = 3'h4
  } pwr_state_t;

  typedef enum logic [6:0] {
    I_IDLE = 7'h01,
    I_ADDR = 7'h02,
    I_ACK  = 7'h04,
    I_RXB  = 7'h08,
    I_TXB  = 7'h10,
    I_MACK = 7'h20,
    I_WAIT = 7'h40
  } i2c_state_t;
endpackage

// *** filt_if.sv ***
// Purpose: carries filtered levels and their edge pulses
// Assumes: one bit per external input
// Notes:   edge pulses last one CLK cycle
`timescale 1ns/10ps
interface filt_if #(parameter int W = 1);
  logic [W-1:0] lvl;
  logic [W-1:0] rise;
  logic [W-1:0] fall;
  modport src (output lvl, output rise, output fall);
  modport dst (input lvl, input rise, input fall);
endinterface

// *** glitch_filter.sv ***
// Purpose: synchronise and deglitch asynchronous inputs
// Assumes: inputs come from outside the CLK domain
// Notes:   a level must persist HOLD agreeing samples before it is taken
`timescale 1ns/10ps
module glitch_filter #(
  parameter int W    = 1,
  parameter int HOLD = pmic_pkg::GLITCH_CYC
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] raw,
  filt_if.src               f
);
  localparam int CW = $clog2(HOLD + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(HOLD - 1);

  logic [W-1:0]  s1_q;
  logic [W-1:0]  s2_q;
  logic [W-1:0]  s3_q;
  logic [W-1:0]  lvl_q;
  logic [W-1:0]  rise_q;
  logic [W-1:0]  fall_q;
  logic [CW-1:0] cnt_q [W];

  if (W < 1 || HOLD < 1) begin : g_chk
    $error("glitch_filter: W and HOLD must be at least one");
  end

  // three-stage synchroniser; s1 feeds only s2
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // take a new level only after HOLD agreeing samples, so short spikes vanish
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lvl_q  <= '0;
      rise_q <= '0;
      fall_q <= '0;
      for (int i = 0; i < W; i++) cnt_q[i] <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        rise_q[i] <= 1'b0;
        fall_q[i] <= 1'b0;
        if (s2_q[i] == s3_q[i] && s3_q[i] != lvl_q[i]) begin
          if (cnt_q[i] == CNT_LAST) begin
            lvl_q[i]  <= s3_q[i];
            rise_q[i] <= s3_q[i];
            fall_q[i] <= ~s3_q[i];
            cnt_q[i]  <= '0;
          end else begin
            cnt_q[i] <= cnt_q[i] + 1'b1;
          end
        end else begin
          cnt_q[i] <= '0;
        end
      end
    end
  end

  assign f.lvl  = lvl_q;
  assign f.rise = rise_q;
  assign f.fall = fall_q;
endmodule

// *** pmic_i2c_slave_state_ctrl.sv ***
// Purpose: serial register target and top-level power state controller
// Assumes: comparator and fault inputs are asynchronous levels
// Notes:   sleep, deep-sleep, thermal and output fault states live elsewhere
// Behaviour
// - answer only as target, at one of four factory-selected seven-bit addresses
// - first byte is address plus direction bit, zero write, one read
// - no inactivity timeout; a stalled transfer waits for another event
// - entering low-power or fault states forces the serial engine idle
// - any start condition abandons the current packet and decodes anew
// - serial interface works in every state except cold reset
// - clock and data inputs ignore spikes of up to 50 ns
// - data line is only pulled low, otherwise released
// - volatile registers are config or status with fixed defaults
// - factory-class registers load programmed defaults; writes change working copy
// - in cold reset regulators off and reset outputs low
// - in cold reset all registers return to their defaults
// - leave cold reset for sequence start once input is in window
// - from any state fall to cold reset on input undervoltage
// - sequence start is transitional while regulators ramp up
// - active when input in range, outputs on, no fault; entry here tests window and outputs good only, and only undervoltage leaves it
// - faults are shown in a status register and on a status pin
// - fault reporting maskable; thresholds and response set by configuration; the mask gates only the status pin, not the status register
`timescale 1ns/10ps
module pmic_i2c_slave_state_ctrl #(
  parameter int          N_OUT          = 8,
  parameter logic [1:0]  ADDR_SEL       = pmic_pkg::ADDR_SEL_RST,
  parameter logic [7:0]  VOUT_DEFAULT   = pmic_pkg::VOUT_FACTORY,
  parameter logic [7:0]  FLTCFG_DEFAULT = pmic_pkg::FLTCFG_FACTORY
) (
  input  wire logic             CLK,
  input  wire logic             RESET_N,
  input  wire logic             SCL_I,
  input  wire logic             SDA_I,
  output logic                  SDA_O,
  output logic                  SDA_OE,
  input  wire logic             VIN_ABOVE_UV,
  input  wire logic             VIN_BELOW_OV,
  input  wire logic             OUTPUTS_GOOD,
  input  wire logic             LOWPWR_FAULT_STATE,
  input  wire logic [N_OUT-1:0] OUT_FAULT,
  output logic                  REG_EN,
  output logic [2:0]            RESET_OUT_N,
  output logic                  FAULT_N,
  output logic [7:0]            VOUT_SEL,
  output logic [1:0]            FAULT_THR,
  output logic [2:0]            PWR_STATE
);
  localparam int FW = pmic_pkg::FB_FLT + N_OUT;

  if (N_OUT < 1 || N_OUT > 8) begin : g_chk
    $error("pmic: N_OUT must be 1 to 8");
  end

  filt_if #(.W(FW)) fin ();

  glitch_filter #(.W(FW), .HOLD(pmic_pkg::GLITCH_CYC)) u_filt (
    .clk   (CLK),
    .rst_n (RESET_N),
    .raw   ({OUT_FAULT, LOWPWR_FAULT_STATE, OUTPUTS_GOOD,
             VIN_BELOW_OV, VIN_ABOVE_UV, SDA_I, SCL_I}),
    .f     (fin)
  );

  pmic_pkg::pwr_state_t pwr_q;
  pmic_pkg::i2c_state_t i2c_q;
  logic [3:0]       bit_cnt_q;
  logic [7:0]       shift_q;
  logic [7:0]       tx_q;
  logic [7:0]       ptr_q;
  logic             rw_q;
  logic             first_q;
  logic             mack_q;
  logic             sda_oe_q;
  logic             sda_o_q;
  logic             wr_stb_q;
  logic [7:0]       wr_idx_q;
  logic [7:0]       wr_data_q;
  logic [7:0]       status_q;
  logic [7:0]       mask_q;
  logic [7:0]       vout_q;
  logic [7:0]       fltcfg_q;
  logic             reg_en_q;
  logic [2:0]       rst_out_q;
  logic             fault_n_q;
  logic [6:0]       tgt_addr;
  logic [7:0]       rd_byte;
  logic [7:0]       flt_raw;
  logic             scl_rise;
  logic             scl_fall;
  logic             start;
  logic             stop;
  logic             force_idle;
  logic             uv_ok;
  logic             ov_ok;

  // event decode from filtered pins
  assign scl_rise   = fin.rise[pmic_pkg::FB_SCL];
  assign scl_fall   = fin.fall[pmic_pkg::FB_SCL];
  assign start      = fin.fall[pmic_pkg::FB_SDA] & fin.lvl[pmic_pkg::FB_SCL];
  assign stop       = fin.rise[pmic_pkg::FB_SDA] & fin.lvl[pmic_pkg::FB_SCL];
  assign uv_ok      = fin.lvl[pmic_pkg::FB_UV];
  assign ov_ok      = fin.lvl[pmic_pkg::FB_OV];
  // cold reset holds the engine idle, so bus traffic is ignored there
  assign force_idle = (pwr_q == pmic_pkg::P_RESET) | fin.rise[pmic_pkg::FB_LP];
  assign flt_raw    = 8'(fin.lvl[FW-1:pmic_pkg::FB_FLT]);

  // factory address choice
  always_comb begin
    unique case (ADDR_SEL)
      2'h0:    tgt_addr = pmic_pkg::TGT_ADDR_0;
      2'h1:    tgt_addr = pmic_pkg::TGT_ADDR_1;
      2'h2:    tgt_addr = pmic_pkg::TGT_ADDR_2;
      default: tgt_addr = pmic_pkg::TGT_ADDR_3;
    endcase
  end

  // read mux; unmapped indices read zero
  always_comb begin
    unique case (ptr_q)
      pmic_pkg::REG_STATUS: rd_byte = status_q;
      pmic_pkg::REG_MASK:   rd_byte = mask_q;
      pmic_pkg::REG_VOUT:   rd_byte = vout_q;
      pmic_pkg::REG_FLTCFG: rd_byte = fltcfg_q;
      default:              rd_byte = 8'h00;
    endcase
  end

  // power state controller
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      pwr_q <= pmic_pkg::P_RESET;
    end else if (!uv_ok) begin
      pwr_q <= pmic_pkg::P_RESET;
    end else begin
      unique case (pwr_q)
        pmic_pkg::P_RESET:  if (ov_ok) pwr_q <= pmic_pkg::P_SEQ;
        pmic_pkg::P_SEQ:    if (ov_ok && fin.lvl[pmic_pkg::FB_GOOD]) begin
          pwr_q <= pmic_pkg::P_ACTIVE;
        end
        pmic_pkg::P_ACTIVE: pwr_q <= pmic_pkg::P_ACTIVE;
      endcase
    end
  end

  // regulator enable and reset outputs follow the power state
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      reg_en_q  <= 1'b0;
      rst_out_q <= 3'h0;
    end else begin
      reg_en_q  <= (pwr_q != pmic_pkg::P_RESET);
      rst_out_q <= {3{pwr_q == pmic_pkg::P_ACTIVE}};
    end
  end

  // serial packet engine; waits forever between edges, no timeout
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      i2c_q     <= pmic_pkg::I_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q   <= 8'h00;
      tx_q      <= 8'h00;
      ptr_q     <= 8'h00;
      rw_q      <= 1'b0;
      first_q   <= 1'b0;
      mack_q    <= 1'b0;
      sda_oe_q  <= 1'b0;
      wr_stb_q  <= 1'b0;
      wr_idx_q  <= 8'h00;
      wr_data_q <= 8'h00;
    end else begin
      wr_stb_q <= 1'b0;
      if (force_idle) begin
        i2c_q    <= pmic_pkg::I_IDLE;
        sda_oe_q <= 1'b0;
      end else if (start) begin
        i2c_q     <= pmic_pkg::I_ADDR;
        bit_cnt_q <= 4'h0;
        first_q   <= 1'b1;
        sda_oe_q  <= 1'b0;
      end else if (stop) begin
        i2c_q    <= pmic_pkg::I_IDLE;
        sda_oe_q <= 1'b0;
      end else begin
        unique case (i2c_q)
          pmic_pkg::I_IDLE, pmic_pkg::I_WAIT: sda_oe_q <= 1'b0;
          pmic_pkg::I_ADDR, pmic_pkg::I_RXB: begin
            if (scl_rise) begin
              shift_q   <= {shift_q[6:0], fin.lvl[pmic_pkg::FB_SDA]};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end else if (scl_fall && bit_cnt_q == 4'h8) begin
              bit_cnt_q <= 4'h0;
              if (i2c_q == pmic_pkg::I_ADDR) begin
                if (shift_q[7:1] == tgt_addr) begin
                  rw_q     <= shift_q[0];
                  sda_oe_q <= 1'b1;
                  i2c_q    <= pmic_pkg::I_ACK;
                end else begin
                  i2c_q <= pmic_pkg::I_WAIT;
                end
              end else begin
                sda_oe_q <= 1'b1;
                i2c_q    <= pmic_pkg::I_ACK;
                first_q  <= 1'b0;
                if (first_q) begin
                  ptr_q <= shift_q;
                end else begin
                  wr_stb_q  <= 1'b1;
                  wr_idx_q  <= ptr_q;
                  wr_data_q <= shift_q;
                  ptr_q     <= ptr_q + 8'h01;
                end
              end
            end
          end
          pmic_pkg::I_ACK: if (scl_fall) begin
            if (rw_q) begin
              tx_q     <= rd_byte;
              sda_oe_q <= ~rd_byte[7];
              ptr_q    <= ptr_q + 8'h01;
              i2c_q    <= pmic_pkg::I_TXB;
            end else begin
              sda_oe_q <= 1'b0;
              i2c_q    <= pmic_pkg::I_RXB;
            end
          end
          pmic_pkg::I_TXB: if (scl_fall) begin
            if (bit_cnt_q == 4'h7) begin
              bit_cnt_q <= 4'h0;
              sda_oe_q  <= 1'b0;
              i2c_q     <= pmic_pkg::I_MACK;
            end else begin
              bit_cnt_q <= bit_cnt_q + 4'h1;
              tx_q      <= {tx_q[6:0], 1'b0};
              sda_oe_q  <= ~tx_q[6];
            end
          end
          pmic_pkg::I_MACK: begin
            // a master nack ends the read; a stop or start follows
            if (scl_rise) begin
              mack_q <= ~fin.lvl[pmic_pkg::FB_SDA];
            end else if (scl_fall) begin
              if (mack_q) begin
                tx_q     <= rd_byte;
                sda_oe_q <= ~rd_byte[7];
                ptr_q    <= ptr_q + 8'h01;
                i2c_q    <= pmic_pkg::I_TXB;
              end else begin
                i2c_q <= pmic_pkg::I_WAIT;
              end
            end
          end
        endcase
      end
    end
  end

  // pin drivers; the data output is a constant low, only the enable moves
  always_ff @(posedge CLK) begin
    if (!RESET_N) sda_o_q <= 1'b0;
    else          sda_o_q <= 1'b0;
  end

  // configuration registers; cold reset reloads fixed and factory defaults
  always_ff @(posedge CLK) begin
    if (!RESET_N || pwr_q == pmic_pkg::P_RESET) begin
      mask_q   <= pmic_pkg::MASK_RST;
      vout_q   <= VOUT_DEFAULT;
      fltcfg_q <= FLTCFG_DEFAULT;
    end else if (wr_stb_q) begin
      unique case (wr_idx_q)
        pmic_pkg::REG_MASK:   mask_q   <= wr_data_q;
        pmic_pkg::REG_VOUT:   vout_q   <= wr_data_q;
        pmic_pkg::REG_FLTCFG: fltcfg_q <= wr_data_q;
        default: ;
      endcase
    end
  end

  // fault status: live, or sticky with write-one-to-clear; a new fault beats the clear
  always_ff @(posedge CLK) begin
    if (!RESET_N || pwr_q == pmic_pkg::P_RESET) begin
      status_q <= 8'h00;
    end else if (fltcfg_q[pmic_pkg::FLT_LATCH_BIT]) begin
      if (wr_stb_q && wr_idx_q == pmic_pkg::REG_STATUS) begin
        status_q <= (status_q & ~wr_data_q) | flt_raw;
      end else begin
        status_q <= status_q | flt_raw;
      end
    end else begin
      status_q <= flt_raw;
    end
  end

  // status pin low while any unmasked fault stands in the status register
  always_ff @(posedge CLK) begin
    if (!RESET_N) fault_n_q <= 1'b1;
    else          fault_n_q <= ~|(status_q & ~mask_q);
  end

  assign SDA_O       = sda_o_q;
  assign SDA_OE      = sda_oe_q;
  assign REG_EN      = reg_en_q;
  assign RESET_OUT_N = rst_out_q;
  assign FAULT_N     = fault_n_q;
  assign VOUT_SEL    = vout_q;
  assign FAULT_THR   = fltcfg_q[pmic_pkg::FLT_THR_LSB +: 2];
  assign PWR_STATE   = pwr_q;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  a_lp_forces_idle: assert property (fin.rise[pmic_pkg::FB_LP] |=>
    i2c_q == pmic_pkg::I_IDLE && !sda_oe_q) else $error("engine not idle after low-power entry");
  a_start_restarts: assert property (start && !force_idle |=>
    i2c_q == pmic_pkg::I_ADDR && bit_cnt_q == 4'h0) else $error("start did not restart packet");
  a_reset_ignores_bus: assert property ($past(pwr_q) == pmic_pkg::P_RESET &&
    pwr_q == pmic_pkg::P_RESET |-> !sda_oe_q) else $error("bus driven in cold reset");
  a_reset_outputs_low: assert property (pwr_q == pmic_pkg::P_RESET |=>
    !REG_EN && RESET_OUT_N == 3'h0) else $error("outputs alive in cold reset");
  a_defaults_reload: assert property (pwr_q == pmic_pkg::P_RESET |=>
    mask_q == pmic_pkg::MASK_RST && vout_q == VOUT_DEFAULT && fltcfg_q == FLTCFG_DEFAULT)
    else $error("registers not at defaults in cold reset");
  a_window_to_seq: assert property (pwr_q == pmic_pkg::P_RESET && uv_ok && ov_ok |=>
    pwr_q == pmic_pkg::P_SEQ) else $error("window entry did not start sequence");
  a_uv_to_reset: assert property (!uv_ok |=> pwr_q == pmic_pkg::P_RESET)
    else $error("undervoltage did not force cold reset");
  a_seq_no_release: assert property (pwr_q == pmic_pkg::P_SEQ |=> RESET_OUT_N == 3'h0)
    else $error("reset outputs released during sequence start");
  a_active_entry: assert property (pwr_q == pmic_pkg::P_SEQ && uv_ok && ov_ok &&
    fin.lvl[pmic_pkg::FB_GOOD] |=> pwr_q == pmic_pkg::P_ACTIVE ##1 RESET_OUT_N == 3'h7)
    else $error("active state not reached");
  // the mask that counts is the one beside the updated status, a write may change it meanwhile
  a_fault_pin_low: assert property (fin.lvl[pmic_pkg::FB_FLT] &&
    pwr_q != pmic_pkg::P_RESET && uv_ok ##1 !mask_q[0] |=> !FAULT_N)
    else $error("unmasked fault not shown");
  a_sda_low_only: assert property (SDA_O == 1'b0)
    else $error("data line driven high");
  a_no_timeout: assert property (i2c_q == pmic_pkg::I_RXB && !force_idle && !start &&
    !stop && !scl_rise && !scl_fall |=> i2c_q == pmic_pkg::I_RXB) else $error("transfer dropped");
  a_addr_mismatch: assert property (i2c_q == pmic_pkg::I_ADDR && scl_fall &&
    bit_cnt_q == 4'h8 && shift_q[7:1] != tgt_addr && !force_idle && !start && !stop
    |=> i2c_q == pmic_pkg::I_WAIT && !sda_oe_q) else $error("foreign address acknowledged");

  c_reg_write:   cover property (wr_stb_q && wr_idx_q == pmic_pkg::REG_MASK);
  c_read_byte:   cover property (i2c_q == pmic_pkg::I_MACK && mack_q);
  c_reach_act:   cover property (pwr_q == pmic_pkg::P_SEQ ##1 pwr_q == pmic_pkg::P_ACTIVE);
  c_mid_restart: cover property (i2c_q == pmic_pkg::I_RXB && start);
endmodule

// *** i2c_host.sv ***
// Purpose: behavioural serial bus master standing on the far side of the target
// Assumes: scl is push-pull from this master, the data wire is wired-and with a pull-up
// Notes:   phases are whole multiples of the 128 ns quarter-bit step, slow enough for the 7-sample filter
`timescale 1ns/10ps
module i2c_host (
  input  wire logic clk,
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  logic glitch;
  // bus idles released; scl is driven high, the pull-up holds the data line high
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
    glitch  = 1'b0;
  end
  // one quarter bit: 128 ns
  task automatic hp;
    repeat (16) @(negedge clk);
  endtask
  // start from either idle or mid-bit low phase
  task automatic start;
    sda_low = 1'b0;
    hp();
    scl = 1'b1;
    hp();
    sda_low = 1'b1;
    hp();
    scl = 1'b0;
    hp();
  endtask
  task automatic stop;
    sda_low = 1'b1;
    hp();
    scl = 1'b1;
    hp();
    sda_low = 1'b0;
    hp();
  endtask
  // only ever pulls low; a one is a released line read back through the pull-up
  task automatic send_bit(input logic b, output logic s);
    sda_low = !b;
    hp();
    scl = 1'b1;
    hp();
    s = sda;
    // a 48 ns low spike inside the high phase must not count as a clock edge
    if (glitch) begin
      scl = 1'b0;
      repeat (6) @(negedge clk);
      scl = 1'b1;
    end
    hp();
    scl = 1'b0;
    hp();
  endtask
  // msb first, then the ninth bit returns the target's acknowledge
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      send_bit(d[i], s);
    end
    send_bit(1'b1, s);
    ack = !s;
  endtask
  // last byte of a read is refused by the master to end the transfer
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      send_bit(1'b1, d[i]);
    end
    send_bit(last, s);
  endtask
endmodule

// *** tb.sv ***
// Purpose: self-checking bench for the serial target and power state controller
// Assumes: target strapped to the first address choice, factory defaults from the package
// Notes:   expectations come from a small register model kept in integers
`timescale 1ns/10ps
module tb;
  localparam logic [7:0] WA = {pmic_pkg::TGT_ADDR_0, 1'b0};
  localparam logic [7:0] RA = {pmic_pkg::TGT_ADDR_0, 1'b1};
  logic        clk = 1'b0, reset_n = 1'b0, above_uv = 1'b0, below_ov = 1'b0;
  logic        good = 1'b0, lowpwr = 1'b0, ack, s;
  logic [7:0]  out_fault = 8'h00, rd;
  logic [31:0] rnd = 32'h2435;
  logic [6:0]  others [3] = '{pmic_pkg::TGT_ADDR_1, pmic_pkg::TGT_ADDR_2, pmic_pkg::TGT_ADDR_3};
  int          error_cnt = 0, check_count = 0, exp_vout, exp_mask, exp_thr;
  wire logic   scl, host_low, sda_o, sda_oe, reg_en, fault_n;
  wire logic [2:0] rst_out_n, pwr;
  wire logic [7:0] vout;
  wire logic [1:0] thr;
  // wired-and data line with pull-up
  wire logic   sda = !((sda_oe && !sda_o) || host_low);

  always #4 clk = ~clk;

  pmic_i2c_slave_state_ctrl u_pmic_i2c_slave_state_ctrl (
    .CLK(clk), .RESET_N(reset_n), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe),
    .VIN_ABOVE_UV(above_uv), .VIN_BELOW_OV(below_ov), .OUTPUTS_GOOD(good),
    .LOWPWR_FAULT_STATE(lowpwr), .OUT_FAULT(out_fault), .REG_EN(reg_en),
    .RESET_OUT_N(rst_out_n), .FAULT_N(fault_n), .VOUT_SEL(vout), .FAULT_THR(thr),
    .PWR_STATE(pwr));
  i2c_host u_i2c_host (.clk(clk), .scl(scl), .sda_low(host_low), .sda(sda));

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // bounded wait for a power state, then compare it
  task automatic wait_pwr(input logic [2:0] v);
    for (int n = 0; n < 200 && pwr !== v; n++) @(negedge clk);
    chk("pwr_state", 8'(pwr), 8'(v));
  endtask
  task automatic wr_reg(input logic [7:0] p, input logic [7:0] d);
    u_i2c_host.start();
    u_i2c_host.wr_byte(WA, ack);
    chk("ack_addr", 8'(ack), 8'h01);
    u_i2c_host.wr_byte(p, ack);
    chk("ack_ptr", 8'(ack), 8'h01);
    u_i2c_host.wr_byte(d, ack);
    chk("ack_data", 8'(ack), 8'h01);
    u_i2c_host.stop();
  endtask
  task automatic rd_reg(input logic [7:0] p, output logic [7:0] d);
    u_i2c_host.start();
    u_i2c_host.wr_byte(WA, ack);
    u_i2c_host.wr_byte(p, ack);
    u_i2c_host.start();
    u_i2c_host.wr_byte(RA, ack);
    chk("ack_read", 8'(ack), 8'h01);
    u_i2c_host.rd_byte(1'b1, d);
    u_i2c_host.stop();
  endtask
  // compare the register model with read-back and pins
  task automatic cmp_regs;
    rd_reg(pmic_pkg::REG_VOUT, rd);
    chk("vout_read", rd, exp_vout[7:0]);
    chk("vout_pin", vout, exp_vout[7:0]);
    rd_reg(pmic_pkg::REG_MASK, rd);
    chk("mask_read", rd, exp_mask[7:0]);
    chk("thr_pin", {6'h0, thr}, {6'h0, exp_thr[2:1]});
  endtask

  // hang guard
  initial begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    finish_test();
  end

  initial begin
    exp_vout = pmic_pkg::VOUT_FACTORY;
    exp_mask = pmic_pkg::MASK_RST;
    exp_thr  = pmic_pkg::FLTCFG_FACTORY;
    repeat (5) @(negedge clk);
    reset_n = 1'b1;
    repeat (20) @(negedge clk);
    chk("pwr_cold", 8'(pwr), 8'h01);
    chk("reg_en_cold", 8'(reg_en), 8'h00);
    chk("rst_out_cold", 8'(rst_out_n), 8'h00);
    chk("vout_cold", vout, exp_vout[7:0]);
    // bus traffic is ignored in cold reset
    u_i2c_host.start();
    u_i2c_host.wr_byte(WA, ack);
    chk("ack_cold", 8'(ack), 8'h00);
    u_i2c_host.stop();
    above_uv = 1'b1;
    below_ov = 1'b1;
    wait_pwr(3'h2);
    // the output pins trail the state register by one clock
    @(negedge clk);
    chk("reg_en_seq", 8'(reg_en), 8'h01);
    chk("rst_out_seq", 8'(rst_out_n), 8'h00);
    good = 1'b1;
    wait_pwr(3'h4);
    repeat (3) @(negedge clk);
    chk("rst_out_act", 8'(rst_out_n), 8'h07);
    // random writes with spikes on the clock line
    u_i2c_host.glitch = 1'b1;
    for (int i = 0; i < 3; i++) begin
      rnd = xs(rnd);
      exp_vout = rnd[7:0];
      exp_thr = rnd[15:8] & 8'h06;
      wr_reg(pmic_pkg::REG_VOUT, exp_vout[7:0]);
      wr_reg(pmic_pkg::REG_FLTCFG, exp_thr[7:0]);
      cmp_regs();
    end
    u_i2c_host.glitch = 1'b0;
    // other strap addresses are never acknowledged, nor what follows
    foreach (others[i]) begin
      u_i2c_host.start();
      u_i2c_host.wr_byte({others[i], 1'b0}, ack);
      chk("ack_other", 8'(ack), 8'h00);
      u_i2c_host.wr_byte(pmic_pkg::REG_VOUT, ack);
      chk("ack_after_other", 8'(ack), 8'h00);
      u_i2c_host.stop();
    end
    // start in the middle of a data byte abandons the old packet
    u_i2c_host.start();
    u_i2c_host.wr_byte(WA, ack);
    u_i2c_host.wr_byte(pmic_pkg::REG_VOUT, ack);
    for (int i = 0; i < 4; i++) u_i2c_host.send_bit(1'b0, s);
    wr_reg(pmic_pkg::REG_MASK, 8'hFF);
    exp_mask = 8'hFF;
    cmp_regs();
    // a long stall mid-transfer must not time out
    u_i2c_host.start();
    u_i2c_host.wr_byte(WA, ack);
    u_i2c_host.wr_byte(pmic_pkg::REG_VOUT, ack);
    repeat (3000) @(negedge clk);
    rnd = xs(rnd);
    exp_vout = rnd[7:0];
    u_i2c_host.wr_byte(exp_vout[7:0], ack);
    chk("ack_stall", 8'(ack), 8'h01);
    u_i2c_host.stop();
    // entering a low-power state drops the open transfer
    u_i2c_host.start();
    u_i2c_host.wr_byte(WA, ack);
    u_i2c_host.wr_byte(pmic_pkg::REG_VOUT, ack);
    lowpwr = 1'b1;
    repeat (30) @(negedge clk);
    u_i2c_host.wr_byte(8'h5A, ack);
    chk("ack_lowpwr", 8'(ack), 8'h00);
    u_i2c_host.stop();
    lowpwr = 1'b0;
    cmp_regs();
    // fault reporting on pin and status register, then masking
    wr_reg(pmic_pkg::REG_MASK, 8'h00);
    exp_mask = 0;
    rnd = xs(rnd);
    out_fault = rnd[7:0] | 8'h01;
    repeat (30) @(negedge clk);
    chk("fault_pin", 8'(fault_n), 8'h00);
    rd_reg(pmic_pkg::REG_STATUS, rd);
    chk("status", rd, out_fault);
    rd_reg(pmic_pkg::REG_MASK, rd);
    chk("mask_rmw", rd, exp_mask[7:0]);
    exp_mask = exp_mask | out_fault;
    wr_reg(pmic_pkg::REG_MASK, rd | out_fault);
    repeat (5) @(negedge clk);
    chk("fault_masked", 8'(fault_n), 8'h01);
    wr_reg(pmic_pkg::REG_STATUS, 8'h00);
    rd_reg(pmic_pkg::REG_STATUS, rd);
    chk("status_ro", rd, out_fault);
    out_fault = 8'h00;
    cmp_regs();
    // sticky status keeps a vanished fault until a one is written over it
    wr_reg(pmic_pkg::REG_FLTCFG, 8'h01);
    out_fault = 8'h04;
    repeat (30) @(negedge clk);
    out_fault = 8'h00;
    rd_reg(pmic_pkg::REG_STATUS, rd);
    chk("status_sticky", rd, 8'h04);
    wr_reg(pmic_pkg::REG_STATUS, 8'h04);
    rd_reg(pmic_pkg::REG_STATUS, rd);
    chk("status_clear", rd, 8'h00);
    // undervoltage returns to cold reset and restores defaults
    above_uv = 1'b0;
    wait_pwr(3'h1);
    repeat (3) @(negedge clk);
    chk("reg_en_uv", 8'(reg_en), 8'h00);
    chk("rst_out_uv", 8'(rst_out_n), 8'h00);
    exp_vout = pmic_pkg::VOUT_FACTORY;
    exp_mask = pmic_pkg::MASK_RST;
    exp_thr  = pmic_pkg::FLTCFG_FACTORY;
    above_uv = 1'b1;
    wait_pwr(3'h2);
    wait_pwr(3'h4);
    cmp_regs();
    finish_test();
  end
endmodule
